// file: abr_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ABR_REGS_SVH
`define ABR_REGS_SVH
`define ABR_OFF_CTRL      8'h00
`define ABR_OFF_DIV_LOW   8'h04
`define ABR_OFF_DIV_HIGH  8'h08
`define ABR_OFF_RX_DATA   8'h0c
`define ABR_OFF_TX_DATA   8'h10
`define ABR_BIT_ASYNC     0
`define ABR_BIT_WAKE      1
`define ABR_BIT_AUTOBAUD  2
`define ABR_BIT_WIDE      3
`define ABR_BIT_HSPEED    4
`define ABR_BIT_RXIRQ     5
`define ABR_BIT_MEASURE   6
`define ABR_BIT_OVF       7
`define ABR_CTRL_RESET    6'h00
`define ABR_DIV_RESET     16'h0000
`define ABR_MEAS_PERIOD   9'h1ff
`define ABR_HALF_PERIOD   9'h01f
`define ABR_LAST_EDGE     3'h4
`endif

// file: abr_pkg.sv
// types shared by the autobaud serial receive block
package abr_pkg;
    typedef enum logic [2:0] {
        MEAS_OFF   = 3'b000,
        MEAS_BREAK = 3'b001,
        MEAS_START = 3'b010,
        MEAS_RISE  = 3'b011,
        MEAS_COUNT = 3'b100
    } abr_meas_e_t;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } abr_rx_e_t;
    typedef struct packed {
        logic autobaud_overflow_flag;
        logic high_speed_baud_select;
        logic wide_divisor_select;
        logic autobaud_enable;
        logic wake_on_rx_enable;
        logic async_mode;
    } abr_ctrl_t;
    typedef struct packed {
        abr_rx_e_t   st;
        logic [16:0] cnt;
        logic [2:0]  bitn;
        logic [7:0]  data;
        logic        valid;
    } abr_rx_st_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        abr_ctrl_t   ctrl;
        logic [15:0] div;
        abr_meas_e_t meas;
        logic [2:0]  edges;
        logic        rx_prev;
        logic        rxif;
        logic [7:0]  rxdata;
        logic [7:0]  txdata;
        logic        tx_load;
        logic        measuring;
    } abr_top_st_t;
endpackage

// file: abr_presc.sv
// prescaler: one-cycle tick for the measure counter or the receive half-unit
`timescale 1ns/100ps
`include "abr_regs.svh"
module abr_presc #(
    parameter int CNT_W = 9
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // rate selection
    input  wire logic       meas_mode,
    input  wire logic [1:0] sel_count,
    // tick out
    output logic            tick
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } abr_presc_st_t;

    abr_presc_st_t q;       // registered state
    abr_presc_st_t next_q;  // next state
    logic [CNT_W-1:0] last; // terminal count

    // refuse a counter too narrow for the slowest rate
    if (CNT_W < 9) begin : g_chk
        $error("abr_presc: CNT_W below 9");
    end

    ////////////////////////////////////////////////////////////////////
    // period: 512/128/32 while measuring, 32/8/2 for reception
    always_comb begin
        last = CNT_W'((meas_mode ? `ABR_MEAS_PERIOD : `ABR_HALF_PERIOD) >> {sel_count, 1'b0}); // RULE_10 RULE_11
        next_q = q;
        next_q.tick = 1'b0;
        if (q.cnt >= last) begin
            next_q.cnt = '0;
            next_q.tick = 1'b1;
        end else begin
            next_q.cnt = q.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tick = q.tick;
endmodule // abr_presc

// file: abr_rx.sv
// asynchronous 8-bit receiver timed by the baud divisor
`timescale 1ns/100ps
module abr_rx
    import abr_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        hold,
    input  wire logic        half_tick,
    input  wire logic [15:0] divisor,
    // line
    input  wire logic        rx,
    // received byte
    output logic             valid,
    output logic [7:0]       data
);
    abr_rx_st_t q;        // registered state
    abr_rx_st_t next_q;   // next state
    logic [16:0] bit_end; // half ticks per bit, less one

    ////////////////////////////////////////////////////////////////////
    // start found mid-bit, then one sample per bit time
    always_comb begin
        bit_end = {divisor, 1'b1};
        next_q = q;
        next_q.valid = 1'b0;
        if (hold) begin
            // kept idle while the line is being measured
            next_q.st = RX_IDLE; // RULE_13
            next_q.cnt = '0;
        end else begin
            case (q.st)
                RX_IDLE: begin
                    if (!rx) begin
                        next_q.st = RX_START;
                        next_q.cnt = '0;
                    end
                end
                RX_START: begin
                    if (half_tick && q.cnt == {1'b0, divisor}) begin
                        next_q.st = rx ? RX_IDLE : RX_DATA;
                        next_q.cnt = '0;
                        next_q.bitn = '0;
                    end else if (half_tick) begin
                        next_q.cnt = q.cnt + 1'b1;
                    end
                end
                RX_DATA: begin
                    if (half_tick && q.cnt == bit_end) begin
                        next_q.data = {rx, q.data[7:1]};
                        next_q.cnt = '0;
                        next_q.bitn = q.bitn + 1'b1;
                        if (q.bitn == 3'h7) begin
                            next_q.st = RX_STOP;
                        end
                    end else if (half_tick) begin
                        next_q.cnt = q.cnt + 1'b1;
                    end
                end
                RX_STOP: begin
                    if (half_tick && q.cnt == bit_end) begin
                        next_q.valid = rx;
                        next_q.st = RX_IDLE;
                    end else if (half_tick) begin
                        next_q.cnt = q.cnt + 1'b1;
                    end
                end
                default: begin
                    next_q.st = RX_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign valid = q.valid;
    assign data = q.data;
endmodule // abr_rx

// file: abr_autobaud.sv
// autobaud measurement with apb registers and divisor-timed receiver
// Functional notes
// RULE_01: measure only in async mode, wake clear; with wake set the block waits out the break, which clears wake
// RULE_02: start bit with enable set starts measuring
// RULE_03: enable set clears divisor, awaits start bit
// RULE_04: remote sends 55h calibration byte
// RULE_05: count from first rising edge on pin
// RULE_06: fifth rising edge stores count, clears enable
// RULE_07: counter rollover sets overflow flag
// RULE_08: overflow set by hardware, writable by software
// RULE_09: rollover keeps measuring, enable stays set
// RULE_10: counter runs at one eighth baud clock
// RULE_11: rates 512, 128, 32 by selects
// RULE_12: always a 16-bit counter while measuring
// RULE_13: receiver held idle while measuring
// RULE_14: fifth rising edge sets receive flag
// RULE_15: receive data read clears flag
// RULE_16: wake set measures byte after break
// RULE_17: transmit data writes refused while enabled
// RULE_18: software avoids enabling during transmission
// RULE_19: software checks high divisor zero
// RULE_20: measured divisor used for later reception
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "abr_regs.svh"
module abr_autobaud
    import abr_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial line
    input  wire logic        serial_receive_pin,
    // status
    output logic             receive_irq_flag,
    output logic             autobaud_measure_mode,
    // transmit hand-off
    output logic [7:0]       tx_byte,
    output logic             tx_load
);
    abr_top_st_t q;        // registered state
    abr_top_st_t next_q;   // next state
    logic        tick;     // prescaler tick
    logic        rx_valid; // byte received
    logic [7:0]  rx_byte;  // received byte
    logic        acc;      // access phase
    logic        done;     // transfer completes
    logic        rise;     // rising edge on pin
    logic        fall;     // falling edge on pin
    logic        rx_hold;  // receiver held idle
    logic [15:0] rx_div;   // divisor seen by receiver
    logic [1:0]  sel_n;    // number of rate selects set
    logic        last_edge; // fifth rising edge now
    logic        tx_refuse; // write to transmit refused

    ////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic hit(input logic [7:0] a);
        hit = (a == `ABR_OFF_CTRL) || (a == `ABR_OFF_DIV_LOW) ||
              (a == `ABR_OFF_DIV_HIGH) || (a == `ABR_OFF_RX_DATA) ||
              (a == `ABR_OFF_TX_DATA);
    endfunction

    // read mux
    function automatic logic [31:0] rd(input logic [7:0] a, input abr_top_st_t s);
        rd = 32'h0000_0000;
        case (a)
            `ABR_OFF_CTRL: begin
                rd[`ABR_BIT_ASYNC]    = s.ctrl.async_mode;
                rd[`ABR_BIT_WAKE]     = s.ctrl.wake_on_rx_enable;
                rd[`ABR_BIT_AUTOBAUD] = s.ctrl.autobaud_enable;
                rd[`ABR_BIT_WIDE]     = s.ctrl.wide_divisor_select;
                rd[`ABR_BIT_HSPEED]   = s.ctrl.high_speed_baud_select;
                rd[`ABR_BIT_RXIRQ]    = s.rxif;
                rd[`ABR_BIT_MEASURE]  = (s.meas != MEAS_OFF);
                rd[`ABR_BIT_OVF]      = s.ctrl.autobaud_overflow_flag;
            end
            `ABR_OFF_DIV_LOW:  rd[7:0] = s.div[7:0];
            `ABR_OFF_DIV_HIGH: rd[7:0] = s.div[15:8];
            `ABR_OFF_RX_DATA:  rd[7:0] = s.rxdata;
            `ABR_OFF_TX_DATA:  rd[7:0] = s.txdata;
            default:           rd = 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // counter clock and receiver
    assign sel_n = {1'b0, q.ctrl.wide_divisor_select} + {1'b0, q.ctrl.high_speed_baud_select};

    // free-running divider; its phase is not reset at a run start,
    // so a measured count may be one tick off
    abr_presc #(
        .CNT_W     (9)
    ) u_presc (
        .pclk      (pclk),
        .presetn   (presetn),
        .meas_mode (q.meas != MEAS_OFF),
        .sel_count (sel_n),
        .tick      (tick)
    );

    // 8-bit divisor unless wide select set
    assign rx_div = q.ctrl.wide_divisor_select ? q.div : {8'h00, q.div[7:0]}; // RULE_20
    assign rx_hold = (q.meas != MEAS_OFF) || !q.ctrl.async_mode; // RULE_13

    // receiver paced by half ticks of the same divider,
    // held idle for the whole measurement
    abr_rx u_rx (
        .pclk      (pclk),
        .presetn   (presetn),
        .hold      (rx_hold),
        .half_tick (tick),
        .divisor   (rx_div),
        .rx        (serial_receive_pin),
        .valid     (rx_valid),
        .data      (rx_byte)
    );

    ////////////////////////////////////////////////////////////////////
    // bus side, then hardware events, which win over software
    assign acc = psel && penable;
    assign done = acc && q.pready;
    // edges against last cycle's pin sample, which resets high
    // so that the idle line shows no edge out of reset
    assign rise = serial_receive_pin && !q.rx_prev;
    assign fall = !serial_receive_pin && q.rx_prev;
    assign last_edge = (q.meas == MEAS_COUNT) && rise && (q.edges == `ABR_LAST_EDGE);
    assign tx_refuse = pwrite && (paddr == `ABR_OFF_TX_DATA) && q.ctrl.autobaud_enable;

    // bus first, then receiver, then sequencer:
    // hardware sets come after software writes,
    // so an event and a clear in one cycle
    // leave the flag set
    always_comb begin
        next_q = q;
        next_q.tx_load = 1'b0;
        next_q.rx_prev = serial_receive_pin;
        // one wait state, answer registered
        next_q.pready = acc && !q.pready;
        if (acc && !q.pready) begin
            next_q.prdata = rd(paddr, q);
            next_q.pslverr = !hit(paddr) || tx_refuse; // RULE_17
        end
        if (done && pwrite) begin
            case (paddr)
                `ABR_OFF_CTRL: begin
                    next_q.ctrl.async_mode = pwdata[`ABR_BIT_ASYNC];
                    next_q.ctrl.wake_on_rx_enable = pwdata[`ABR_BIT_WAKE];
                    next_q.ctrl.autobaud_enable = pwdata[`ABR_BIT_AUTOBAUD];
                    next_q.ctrl.wide_divisor_select = pwdata[`ABR_BIT_WIDE];
                    next_q.ctrl.high_speed_baud_select = pwdata[`ABR_BIT_HSPEED];
                    next_q.ctrl.autobaud_overflow_flag = pwdata[`ABR_BIT_OVF]; // RULE_08
                end
                `ABR_OFF_DIV_LOW:  next_q.div[7:0] = pwdata[7:0];
                `ABR_OFF_DIV_HIGH: next_q.div[15:8] = pwdata[7:0];
                `ABR_OFF_TX_DATA: begin
                    // ignored while autobaud enable is set
                    if (!q.ctrl.autobaud_enable) begin // RULE_17
                        next_q.txdata = pwdata[7:0];
                        next_q.tx_load = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // reading received data clears the flag
        if (done && !pwrite && paddr == `ABR_OFF_RX_DATA) begin
            next_q.rxif = 1'b0; // RULE_15
        end

        // received byte
        if (rx_valid) begin
            next_q.rxdata = rx_byte;
            next_q.rxif = 1'b1;
        end

        // measurement sequencer
        case (q.meas)
            // idle until enabled in async mode
            MEAS_OFF: begin
                if (q.ctrl.autobaud_enable && q.ctrl.async_mode) begin
                    next_q.div = `ABR_DIV_RESET; // RULE_03
                    next_q.meas = q.ctrl.wake_on_rx_enable ? MEAS_BREAK : MEAS_START; // RULE_01 RULE_16
                end
            end
            // wake mode: the break is not measured
            MEAS_BREAK: begin
                // end of break wakes the port, next byte is measured
                if (rise) begin
                    next_q.ctrl.wake_on_rx_enable = 1'b0; // RULE_16
                    next_q.meas = MEAS_START;
                end
            end
            // falling edge of the start bit
            MEAS_START: begin
                if (fall) begin
                    next_q.meas = MEAS_RISE; // RULE_02
                end
            end
            // first rise ends the start bit
            MEAS_RISE: begin
                if (rise) begin
                    next_q.meas = MEAS_COUNT; // RULE_05
                    next_q.edges = 3'h1;
                end
            end
            // count ticks up to the fifth rise
            MEAS_COUNT: begin
                if (tick) begin
                    next_q.div = q.div + 1'b1; // RULE_05 RULE_12
                    if (q.div == 16'hffff) begin
                        next_q.ctrl.autobaud_overflow_flag = 1'b1; // RULE_07 RULE_09
                    end
                end
                if (last_edge) begin
                    // count stays in divisor pair
                    next_q.meas = MEAS_OFF; // RULE_06
                    next_q.ctrl.autobaud_enable = 1'b0;
                    next_q.rxif = 1'b1; // RULE_14
                end else if (rise) begin
                    next_q.edges = q.edges + 1'b1;
                end
            end
            default: begin
                next_q.meas = MEAS_OFF;
            end
        endcase

        // software cleared enable or left async mode
        if (!(next_q.ctrl.autobaud_enable && next_q.ctrl.async_mode)) begin
            next_q.meas = MEAS_OFF;
        end

        // measure flag in its own flop, so the
        // output comes straight from a register
        next_q.measuring = (next_q.meas != MEAS_OFF);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.rx_prev <= 1'b1; // line idles high
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from flops
    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign receive_irq_flag = q.rxif;
    assign autobaud_measure_mode = q.measuring;
    assign tx_byte = q.txdata;
    assign tx_load = q.tx_load;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a run opens with a cleared divisor
    chk_div_clear: assert property ( // RULE_03
        q.meas == MEAS_OFF && q.ctrl.autobaud_enable && q.ctrl.async_mode && !(done && pwrite)
        |=> q.div == 16'h0000 && q.meas != MEAS_OFF)
        else $error("divisor not cleared");

    // never running outside async mode
    // or with enable clear
    chk_meas_gate: assert property ( // RULE_01
        q.meas != MEAS_OFF
        |-> q.ctrl.async_mode && q.ctrl.autobaud_enable)
        else $error("measuring outside async");

    // wake mode waits for the end of break
    chk_wake_wait: assert property ( // RULE_16
        q.meas == MEAS_BREAK && !rise && !(done && pwrite)
        |=> q.meas == MEAS_BREAK)
        else $error("break skipped");

    // each tick steps all sixteen bits,
    // whatever the wide select holds
    chk_count_step: assert property ( // RULE_12
        q.meas == MEAS_COUNT && tick && !(done && pwrite)
        |=> q.div == $past(q.div) + 16'h0001)
        else $error("counter did not step");

    // rollover raises the sticky flag
    chk_ovf_set: assert property ( // RULE_07
        q.meas == MEAS_COUNT && tick && q.div == 16'hffff && !(done && pwrite)
        |=> q.ctrl.autobaud_overflow_flag && q.div == 16'h0000)
        else $error("overflow not flagged");

    // rollover alone never ends a run
    chk_ovf_keep: assert property ( // RULE_09
        q.meas == MEAS_COUNT && tick && q.div == 16'hffff && !last_edge && !(done && pwrite)
        |=> q.ctrl.autobaud_enable && q.meas == MEAS_COUNT)
        else $error("rollover ended measure");

    // fifth rise ends the run, drops enable
    // and raises the receive flag
    chk_fifth_edge: assert property ( // RULE_06 RULE_14
        last_edge && !(done && pwrite)
        |=> !q.ctrl.autobaud_enable && q.rxif && q.meas == MEAS_OFF)
        else $error("fifth edge not handled");

    // a held receiver delivers nothing
    chk_rx_idle: assert property ( // RULE_13
        q.meas != MEAS_OFF ##1 q.meas != MEAS_OFF
        |-> !rx_valid)
        else $error("receiver not idle");

    // refused write neither loads nor stores
    chk_tx_refused: assert property ( // RULE_17
        done && tx_refuse
        |=> !q.tx_load && $stable(q.txdata))
        else $error("transmit write accepted");

    // data read clears the flag unless
    // a byte or the fifth rise sets it again
    chk_rd_clear: assert property ( // RULE_15
        done && !pwrite && paddr == `ABR_OFF_RX_DATA && !rx_valid && !last_edge
        |=> !q.rxif)
        else $error("read did not clear flag");

    // finished run, rollover, received byte,
    // refused transmit write
    cov_measure_done: cover property (last_edge);
    cov_overflow: cover property (q.meas == MEAS_COUNT && tick && q.div == 16'hffff);
    cov_rx_byte: cover property (rx_valid);
    cov_tx_refused: cover property (done && tx_refuse);
endmodule // abr_autobaud

// file: abr_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/100ps
module abr_tx_model (
    // clock
    input  wire logic pclk,
    // serial line
    output logic      line
);
    // the line rests high between frames
    initial line = 1'b1;

    ////////////////////////////////////////////////////////////////
    // one 8n1 frame, lsb first, bc clocks a bit
    task automatic send(input logic [7:0] b, input int bc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line <= f[i];
            repeat (bc) @(posedge pclk);
        end
    endtask

    // break: long low, then a short idle before the next frame
    task automatic brk(input int n);
        line <= 1'b0;
        repeat (n) @(posedge pclk);
        line <= 1'b1;
        repeat (n / 8) @(posedge pclk);
    endtask
endmodule // abr_tx_model

// file: tb.sv
// self-checking bench for the autobaud block
`timescale 1ns/100ps
`include "abr_regs.svh"
module tb;
    // apb drive and design outputs
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        rx_line;
    logic        irq;
    logic        meas;
    logic [7:0]  tx_byte;
    logic        tx_load;
    // counters and model state
    int          miscompares;
    int          n_checks;
    int          n_load;
    int          bcs[4] = '{1024, 1024, 4112, 400};
    logic [31:0] seed;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  rx_q[$];

    abr_autobaud abr_autobaud_i (
        .pclk                  (pclk),
        .presetn               (presetn),
        .psel                  (psel),
        .penable               (penable),
        .pwrite                (pwrite),
        .paddr                 (paddr),
        .pwdata                (pwdata),
        .pready                (pready),
        .prdata                (prdata),
        .pslverr               (pslverr),
        .serial_receive_pin    (rx_line),
        .receive_irq_flag      (irq),
        .autobaud_measure_mode (meas),
        .tx_byte               (tx_byte),
        .tx_load               (tx_load)
    );
    abr_tx_model abr_tx_model_i (
        .pclk (pclk),
        .line (rx_line)
    );

    ////////////////////////////////////////////////////////////////
    // clock, transmit pulse count, hang guard
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (tx_load === 1'b1) n_load++;
    end
    initial begin
        repeat (98000) @(posedge pclk);
        miscompares++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////
    // verdict and compares
    task automatic close_out();
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // measured count: prescaler phase allows one tick either way
    task automatic chk_near(input string nm, input int exp, input logic [15:0] got);
        n_checks++;
        if ($isunknown(got) || got > exp + 1 || got + 1 < exp) begin
            miscompares++;
            $display("ERROR %s expected %0d seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    ////////////////////////////////////////////////////////////////
    // one apb transfer; holds the request until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // full measurement of a 55h byte; sel[0] wide, sel[1] high speed; ovf presets the top count
    task automatic measure(input logic [1:0] sel, input int bc, input logic wake, input logic ovf);
        int          ex;
        logic [31:0] lo;
        ex = 8 * bc / (512 >> (2 * (int'(sel[0]) + int'(sel[1]))));
        apb(1'b1, `ABR_OFF_DIV_LOW, 32'hff);
        apb(1'b1, `ABR_OFF_DIV_HIGH, 32'hff);
        apb(1'b1, `ABR_OFF_CTRL, {27'h0, sel, 1'b1, wake, 1'b1});
        repeat (3) @(posedge pclk);
        chk("measure_mode", 32'h1, {31'h0, meas});
        apb(1'b0, `ABR_OFF_DIV_LOW, 32'h0);
        chk("div_cleared", 32'h0, rd);
        apb(1'b1, `ABR_OFF_TX_DATA, 32'h3c);
        chk("tx_refused", 32'h1, {31'h0, err});
        // top count rolls over on the first tick
        if (ovf) begin
            apb(1'b1, `ABR_OFF_DIV_LOW, 32'hff);
            apb(1'b1, `ABR_OFF_DIV_HIGH, 32'hff);
            ex = ex - 1;
        end
        if (wake) abr_tx_model_i.brk(13 * bc);
        abr_tx_model_i.send(8'h55, bc);
        chk("measure_end", 32'h0, {31'h0, meas});
        chk("irq_flag", 32'h1, {31'h0, irq});
        apb(1'b0, `ABR_OFF_CTRL, 32'h0);
        chk("ctrl_after", {24'h0, ovf, 2'b01, sel, 3'b001}, rd);
        apb(1'b0, `ABR_OFF_DIV_LOW, 32'h0);
        lo = rd;
        apb(1'b0, `ABR_OFF_DIV_HIGH, 32'h0);
        chk_near("divisor", ex, {rd[7:0], lo[7:0]});
        if (ex < 255) chk("div_high", 32'h0, rd);
        apb(1'b0, `ABR_OFF_RX_DATA, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq_clear", 32'h0, {31'h0, irq});
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int       n;
        logic [7:0] b;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 32'h000165fe;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of every register
        for (int a = 0; a < 20; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk("reset_value", 32'h0, rd);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        // overflow flag is writable both ways
        apb(1'b1, `ABR_OFF_CTRL, 32'h80);
        apb(1'b0, `ABR_OFF_CTRL, 32'h0);
        chk("ovf_set", 32'h80, rd);
        apb(1'b1, `ABR_OFF_CTRL, 32'h0);
        apb(1'b0, `ABR_OFF_CTRL, 32'h0);
        chk("ovf_clear", 32'h0, rd);
        // enable without async mode does not measure
        apb(1'b1, `ABR_OFF_CTRL, 32'h04);
        repeat (3) @(posedge pclk);
        chk("no_async", 32'h0, {31'h0, meas});
        apb(1'b1, `ABR_OFF_CTRL, 32'h0);
        // transmit write accepted while disabled
        seed = lfsr(seed);
        apb(1'b1, `ABR_OFF_TX_DATA, {24'h0, seed[7:0]});
        repeat (2) @(posedge pclk);
        chk("tx_byte", {24'h0, seed[7:0]}, {24'h0, tx_byte});
        chk("tx_loads", 32'h1, n_load);
        // every rate selection, then overflow, then wake mode
        for (int i = 0; i < 4; i++) measure(2'(i), bcs[i], 1'b0, 1'b0);
        measure(2'b11, 400, 1'b0, 1'b1);
        measure(2'b11, 400, 1'b1, 1'b0);
        chk("tx_loads", 32'h1, n_load);
        // reception at the measured rate
        seed = lfsr(seed);
        b = seed[7:0];
        rx_q.push_back(b);
        abr_tx_model_i.send(b, 400);
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        chk("rx_irq", 32'h1, {31'h0, irq});
        apb(1'b0, `ABR_OFF_RX_DATA, 32'h0);
        chk("rx_data", {24'h0, rx_q.pop_front()}, rd);
        close_out();
    end
endmodule // tb
